// *** hdl/acs_sequencer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module acs_sequencer #(
  parameter NCH = 8
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Modulator and front end
  input  wire [23:0] modResult,
  input  wire        modValid,
  input  wire        refMissing,
  output reg         modClk_r,
  output reg         chopInvert_r,
  output reg         inputShort_r,
  output reg  [2:0]  muxChannel_r,
  output reg         sampling_r,
  // Pins
  input  wire        startHoldPin,
  output reg         doneN_r
);
  localparam ST_IDLE = 3'd0, ST_HOLD = 3'd1, ST_SET1 = 3'd2, ST_SAMP1 = 3'd3;
  localparam ST_SET2 = 3'd4, ST_SAMP2 = 3'd5, ST_SCALE = 3'd6;
  // Phase lengths sized to the counter so loads never truncate silently
  localparam [11:0] SET_CHOP  = `ACS_SETTLE_CHOP;
  localparam [11:0] SCALE_LEN = `ACS_SCALE_CYC;

  reg [2:0]  state_r;
  reg [2:0]  mode_r;
  reg        sat_r;
  reg        holdEn_r;
  reg [2:0]  selCh_r;
  reg [11:0] cnt_r;
  reg [NCH-1:0] convDone_r;
  reg [23:0] adcZs_r;
  reg [23:0] adcFs_r;
  reg [10:0] chSet_r [0:NCH-1];
  reg [22:0] chZs_r  [0:NCH-1];
  reg [23:0] chFs_r  [0:NCH-1];
  reg [15:0] chData_r [0:NCH-1];
  reg [3:0]  chStat_r [0:NCH-1];
  reg [24:0] acc1_r;
  reg [24:0] acc2_r;
  reg        holdS1_r, holdS2_r, holdD_r;
  reg        refS1_r, refS2_r;
  reg        missing_reference_flag_r;
  reg        rdErr;
  reg [31:0] rdMux;
  integer    i;

  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & penable & ~pwrite;
  wire [2:0] aCh = paddr[4:2];
  wire modeWr = apbWr && paddr == `ACS_MODE_ADDR;
  wire isCal = mode_r[2];
  wire holdRise = holdS2_r & ~holdD_r;
  wire chopOn = chSet_r[selCh_r][`ACS_CS_CHOP_BIT] & ~isCal;
  // Sampling length: time word with its low bit forced to one, times a fixed unit, so at least one unit
  wire [11:0] sampLen = {chSet_r[selCh_r][7:0] | 8'h01, 4'h0};
  wire [11:0] settleLen = modClk_r ? 12'd44 : 12'd43;

  function [2:0] nextEn;
    input [2:0] cur;
    input [NCH-1:0] en;
    integer k;
    reg [2:0] c;
    begin
      nextEn = cur;
      for (k = NCH; k >= 1; k = k - 1) begin
        c = cur + k[2:0];
        if (en[c]) begin
          nextEn = c;
        end
      end
    end
  endfunction

  reg [NCH-1:0] enMask;
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      enMask[i] = chSet_r[i][`ACS_CS_EN_BIT];
    end
  end

  // Calibration arithmetic on the averaged filter word
  reg [24:0] avg;
  reg signed [49:0] s1;
  reg signed [49:0] s2;
  reg signed [49:0] s3;
  reg [15:0] code;
  reg        pol, range_exceed_flag;
  always @* begin
    avg = chopOn ? ((acc1_r + acc2_r) >> 1) : acc1_r;
    s1 = ($signed({25'h0, avg}) - $signed({26'h0, adcZs_r}))
         * $signed({26'h0, adcFs_r});
    if (chSet_r[selCh_r][`ACS_CS_UNI_BIT]) begin
      s2 = s1 >>> `ACS_UNI_DIV_SH;
    end else begin
      s2 = (s1 >>> `ACS_BIP_DIV_SH) + $signed({25'h0, `ACS_BIP_OFS});
    end
    // Sign plus 22-bit offset magnitude
    if (chZs_r[selCh_r][22]) begin
      s2 = s2 + $signed({28'h0, chZs_r[selCh_r][21:0]});
    end else begin
      s2 = s2 - $signed({28'h0, chZs_r[selCh_r][21:0]});
    end
    s3 = (s2 * $signed({26'h0, chFs_r[selCh_r]})) >>> `ACS_UNI_DIV_SH;
    pol = chSet_r[selCh_r][`ACS_CS_UNI_BIT] ? s3[49] : (s3 < 50'sh800000);
    range_exceed_flag = s3[49] ? chSet_r[selCh_r][`ACS_CS_UNI_BIT] | (s3 < -50'sh1) & 1'b0 | s3[49]
                 : (s3 > 50'shFFFFFF);
    if (chSet_r[selCh_r][`ACS_CS_UNI_BIT] && s3[49]) begin
      code = 16'h0000;
    end else if (sat_r && range_exceed_flag) begin
      code = pol ? 16'h0000 : 16'hFFFF;
    end else begin
      code = s3[23:8];
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      mode_r <= `ACS_MODE_IDLE;
      sat_r <= 1'b0;
      holdEn_r <= 1'b0;
      selCh_r <= 3'h0;
      cnt_r <= 12'h000;
      convDone_r <= {NCH{1'b0}};
      adcZs_r <= `ACS_ADCZS_RST;
      adcFs_r <= `ACS_ADCFS_RST;
      acc1_r <= 25'h0;
      acc2_r <= 25'h0;
      holdS1_r <= 1'b0;
      holdS2_r <= 1'b0;
      holdD_r <= 1'b0;
      refS1_r <= 1'b0;
      refS2_r <= 1'b0;
      missing_reference_flag_r <= 1'b0;
      modClk_r <= 1'b0;
      chopInvert_r <= 1'b0;
      inputShort_r <= 1'b0;
      muxChannel_r <= 3'h0;
      sampling_r <= 1'b0;
      doneN_r <= 1'b1;
      for (i = 0; i < NCH; i = i + 1) begin
        chSet_r[i] <= `ACS_CHSET_RST;
        chZs_r[i] <= 23'h0;
        chFs_r[i] <= `ACS_CHFS_RST;
        chData_r[i] <= 16'h0;
        chStat_r[i] <= 4'h0;
      end
    end else begin
      modClk_r <= ~modClk_r;
      holdS1_r <= startHoldPin;
      holdS2_r <= holdS1_r;
      holdD_r <= holdS2_r;
      refS1_r <= refMissing;
      refS2_r <= refS1_r;
      if (apbRd && paddr >= `ACS_DATA_BASE && paddr < `ACS_CHST_BASE) begin
        convDone_r[aCh] <= 1'b0;
      end
      if (apbWr && state_r == ST_IDLE) begin
        if (paddr == `ACS_CFG_ADDR) holdEn_r <= pwdata[`ACS_CFG_HOLD_BIT];
        else if (paddr == `ACS_ADCZS_ADDR) adcZs_r <= pwdata[23:0];
        else if (paddr == `ACS_ADCFS_ADDR) adcFs_r <= pwdata[23:0];
        else if (paddr[11:5] == `ACS_CHSET_BASE >> 5) chSet_r[aCh] <= pwdata[10:0];
        else if (paddr[11:5] == `ACS_CHZS_BASE >> 5) chZs_r[aCh] <= pwdata[22:0];
        else if (paddr[11:5] == `ACS_CHFS_BASE >> 5) chFs_r[aCh] <= pwdata[23:0];
      end
      cnt_r <= cnt_r - 12'd1;
      case (state_r)
        ST_IDLE: begin
          sampling_r <= 1'b0;
        end
        ST_HOLD: begin
          if (!holdEn_r || holdRise) begin
            state_r <= ST_SET1;
            cnt_r <= settleLen;
          end
        end
        ST_SET1: begin
          if (cnt_r == 12'd1) begin
            state_r <= ST_SAMP1;
            sampling_r <= 1'b1;
            acc1_r <= 25'h0;
            cnt_r <= sampLen;
          end
        end
        ST_SAMP1: begin
          if (modValid) acc1_r <= {1'b0, modResult};
          if (refS2_r) missing_reference_flag_r <= 1'b1;
          if (cnt_r == 12'd1) begin
            sampling_r <= 1'b0;
            if (chopOn) begin
              state_r <= ST_SET2;
              chopInvert_r <= 1'b1;
              cnt_r <= SET_CHOP;
            end else begin
              state_r <= ST_SCALE;
              doneN_r <= 1'b1;
              cnt_r <= SCALE_LEN;
            end
          end
        end
        ST_SET2: begin
          if (cnt_r == 12'd1) begin
            state_r <= ST_SAMP2;
            sampling_r <= 1'b1;
            cnt_r <= sampLen;
          end
        end
        ST_SAMP2: begin
          if (modValid) acc2_r <= {1'b0, ~modResult};
          if (refS2_r) missing_reference_flag_r <= 1'b1;
          if (cnt_r == 12'd1) begin
            sampling_r <= 1'b0;
            chopInvert_r <= 1'b0;
            state_r <= ST_SCALE;
            doneN_r <= 1'b1;
            cnt_r <= SCALE_LEN;
          end
        end
        ST_SCALE: begin
          doneN_r <= 1'b1;
          if (cnt_r == 12'd1) begin
            doneN_r <= 1'b0;
            inputShort_r <= 1'b0;
            missing_reference_flag_r <= 1'b0;
            if (isCal) begin
              if (mode_r == `ACS_MODE_ADCZS) adcZs_r <= acc1_r[23:0];
              else if (mode_r == `ACS_MODE_CHZS)
                chZs_r[selCh_r] <= {1'b0, acc1_r[21:0]};
              else chFs_r[selCh_r] <= acc1_r[23:0];
              convDone_r <= {NCH{1'b1}};
              mode_r <= `ACS_MODE_IDLE;
              state_r <= ST_IDLE;
            end else begin
              if (!(apbRd && paddr == `ACS_DATA_BASE + {7'h0, selCh_r, 2'h0}))
                chData_r[selCh_r] <= code;
              chStat_r[selCh_r] <= {missing_reference_flag_r | refS2_r, range_exceed_flag, pol, 1'b1};
              convDone_r[selCh_r] <= 1'b1;
              if (mode_r == `ACS_MODE_CONT) begin
                selCh_r <= nextEn(selCh_r, enMask);
                muxChannel_r <= nextEn(selCh_r, enMask);
                state_r <= ST_SET1;
                cnt_r <= settleLen;
              end else begin
                mode_r <= `ACS_MODE_IDLE;
                state_r <= ST_IDLE;
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // Mode write wins over any sequence in progress
      if (modeWr) begin
        convDone_r <= {NCH{1'b0}};
        doneN_r <= 1'b1;
        mode_r <= pwdata[2:0];
        sat_r <= pwdata[`ACS_MODE_SAT_BIT];
        selCh_r <= pwdata[`ACS_MODE_CH_LSB+2:`ACS_MODE_CH_LSB];
        muxChannel_r <= pwdata[`ACS_MODE_CH_LSB+2:`ACS_MODE_CH_LSB];
        chopInvert_r <= 1'b0;
        sampling_r <= 1'b0;
        inputShort_r <= pwdata[2:0] == `ACS_MODE_ADCZS;
        state_r <= (pwdata[2:0] == `ACS_MODE_IDLE) ? ST_IDLE : ST_HOLD;
      end
    end
  end

  always @* begin
    rdErr = 1'b0;
    rdMux = 32'h0;
    if (paddr == `ACS_MODE_ADDR)
      rdMux = {25'h0, selCh_r, sat_r, mode_r == `ACS_MODE_IDLE ? 3'h0 : mode_r};
    else if (paddr == `ACS_STAT_ADDR) rdMux = {24'h0, convDone_r};
    else if (paddr == `ACS_CFG_ADDR) rdMux = {31'h0, holdEn_r};
    else if (paddr == `ACS_ADCZS_ADDR) rdMux = {8'h0, adcZs_r};
    else if (paddr == `ACS_ADCFS_ADDR) rdMux = {8'h0, adcFs_r};
    else if (paddr[11:5] == `ACS_CHSET_BASE >> 5) rdMux = {21'h0, chSet_r[aCh]};
    else if (paddr[11:5] == `ACS_CHZS_BASE >> 5) rdMux = {9'h0, chZs_r[aCh]};
    else if (paddr[11:5] == `ACS_CHFS_BASE >> 5) rdMux = {8'h0, chFs_r[aCh]};
    else if (paddr[11:5] == `ACS_DATA_BASE >> 5) rdMux = {16'h0, chData_r[aCh]};
    else if (paddr[11:5] == `ACS_CHST_BASE >> 5) rdMux = {28'h0, chStat_r[aCh]};
    else rdErr = 1'b1;
  end

  // Zero wait state: data is the combinational mux during the access phase
  assign pready = 1'b1;
  assign prdata = rdMux;
  assign pslverr = psel & penable & rdErr;
endmodule
`default_nettype wire

// *** hdl/acs_map.vh ***
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// APB byte addresses
`define ACS_MODE_ADDR     12'h000
`define ACS_STAT_ADDR     12'h004
`define ACS_CFG_ADDR      12'h008
`define ACS_ADCZS_ADDR    12'h00C
`define ACS_ADCFS_ADDR    12'h010
`define ACS_CHSET_BASE    12'h040
`define ACS_CHZS_BASE     12'h080
`define ACS_CHFS_BASE     12'h0C0
`define ACS_DATA_BASE     12'h100
`define ACS_CHST_BASE     12'h140
// Mode register fields
`define ACS_MODE_IDLE     3'h0
`define ACS_MODE_SINGLE   3'h1
`define ACS_MODE_CONT     3'h2
`define ACS_MODE_ADCZS    3'h4
`define ACS_MODE_CHZS     3'h6
`define ACS_MODE_CHFS     3'h7
`define ACS_MODE_SAT_BIT  3
`define ACS_MODE_CH_LSB   4
// Config register fields
`define ACS_CFG_HOLD_BIT  0
// Channel setup fields: [7:0] time word, [8] chop, [9] enable, [10] unipolar
`define ACS_CS_CHOP_BIT   8
`define ACS_CS_EN_BIT     9
`define ACS_CS_UNI_BIT    10
// Channel status fields
`define ACS_CST_DONE_BIT  0
`define ACS_CST_POL_BIT   1
`define ACS_CST_OVR_BIT   2
`define ACS_CST_NREF_BIT  3
// Reset values
`define ACS_ADCZS_RST     24'h000000
`define ACS_ADCFS_RST     24'h200000
`define ACS_CHFS_RST      24'h200000
`define ACS_CHSET_RST     11'h211
// Timing, in master clock cycles
`define ACS_SETTLE_FIRST  43
`define ACS_SETTLE_CHOP   42
`define ACS_SCALE_CYC     163
`define ACS_SAMPLE_UNIT   16
// Scaling constants
`define ACS_UNI_DIV_SH    21
`define ACS_BIP_DIV_SH    22
`define ACS_BIP_OFS       25'h0800000
`endif

// *** sim/acs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module acs_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Converter and pins
  input wire logic        modClk_r,
  input wire logic        chopInvert_r,
  input wire logic        inputShort_r,
  input wire logic        sampling_r,
  input wire logic        startHoldPin,
  input wire logic        doneN_r
);
  logic [7:0] sinceSmp_r;
  logic [7:0] sinceMode_r;
  logic [2:0] mode_r;
  logic       holdEn_r;
  wire        wr = psel && penable && pwrite;
  wire        isCal = mode_r[2];
  // Saturating counters keep long idle stretches from wrapping into a window
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sinceSmp_r <= 8'hFF;
      sinceMode_r <= 8'hFF;
      mode_r <= 3'h0;
      holdEn_r <= 1'b0;
    end else begin
      sinceSmp_r <= sampling_r ? 8'h00 : sinceSmp_r + {7'h0, sinceSmp_r != 8'hFF};
      sinceMode_r <= sinceMode_r + {7'h0, sinceMode_r != 8'hFF};
      if (wr && paddr == `ACS_MODE_ADDR) begin
        mode_r <= pwdata[2:0];
        sinceMode_r <= 8'h00;
      end
      if (wr && paddr == `ACS_CFG_ADDR) begin
        holdEn_r <= pwdata[0];
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_mod_half: assert property ($past(sys_rst) == 1'b0 |-> modClk_r != $past(modClk_r))
    else $error("modulator clock not half rate");
  a_scale_high: assert property (
    !isCal && !sampling_r && sinceSmp_r inside {[50:160]} |-> doneN_r)
    else $error("done pin low during scaling");
  a_done_late: assert property (
    $fell(doneN_r) && !isCal |-> sinceSmp_r inside {[162:165]})
    else $error("scaling length wrong");
  a_chop_gap: assert property (
    $rose(chopInvert_r) |-> $past(sampling_r) && !sampling_r ##[41:43] $rose(sampling_r))
    else $error("chop settle wrong");
  a_first_settle: assert property (
    $rose(sampling_r) && !chopInvert_r && !holdEn_r && !isCal && sinceMode_r < 8'd100
    |-> sinceMode_r inside {[43:48]})
    else $error("first settle wrong");
  a_mode_done: assert property (wr && paddr == `ACS_MODE_ADDR |=> doneN_r)
    else $error("mode write left done pin low");
  a_hold_stop: assert property ((holdEn_r && !startHoldPin) [*4] |-> !sampling_r)
    else $error("sampling while held");
  a_short_zs: assert property (inputShort_r |-> mode_r == `ACS_MODE_ADCZS)
    else $error("inputs shorted outside self calibration");
  cover property ($rose(chopInvert_r));
  cover property ($rose(inputShort_r));
  cover property ($fell(doneN_r) && !isCal);
endmodule
bind acs_sequencer acs_checker chk (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .modClk_r, .chopInvert_r, .inputShort_r, .sampling_r, .startHoldPin, .doneN_r);
`default_nettype wire

// *** sim/acs_mod_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_mod_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Converter side
  input  wire logic        sampling_r,
  input  wire logic        chopInvert_r,
  input  wire logic [23:0] level,
  output var  logic [23:0] modResult,
  output var  logic        modValid
);
  logic [3:0] cnt_r;
  // Strobe mid-block so the last word lands while sampling is still high
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
      modValid <= 1'b0;
      modResult <= 24'h000000;
    end else begin
      cnt_r <= sampling_r ? cnt_r + 4'h1 : 4'h0;
      modValid <= sampling_r && cnt_r == 4'h7;
      // Reversed input during the chopped half reads back as the inverse
      modResult <= (sampling_r && cnt_r == 4'h7) ? level ^ {24{chopInvert_r}} : ~modResult;
    end
  end
endmodule
`default_nettype wire

// *** sim/test_adc_conversion_sequencer_calibration.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module test_adc_conversion_sequencer_calibration;
  logic        sys_clk = 0;
  logic        sys_rst = 1;
  logic        psel = 0, penable = 0, pwrite = 0, refMissing = 0, startHoldPin = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, uni;
  logic        modClk_r, chopInvert_r, inputShort_r, sampling_r, doneN_r, modValid;
  logic [2:0]  muxChannel_r;
  logic [23:0] modResult, level = 0;
  int          miscompares = 0, checks = 0, seed = 39, i, ch;
  always #5 sys_clk = ~sys_clk;
  acs_sequencer dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .modResult, .modValid, .refMissing, .modClk_r, .chopInvert_r,
    .inputShort_r, .muxChannel_r, .sampling_r, .startHoldPin, .doneN_r);
  acs_mod_model mdl (.sys_clk, .sys_rst, .sampling_r, .chopInvert_r, .level, .modResult,
    .modValid);
  task automatic test_done;
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Done pin must first be high, then fall
  task automatic waitDone;
    int n;
    n = 0;
    while (doneN_r !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    while (doneN_r !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      test_done;
    end
  endtask
  function automatic logic [31:0] expData(input logic [23:0] r, input logic u);
    return u ? {16'h0000, r[23:8]} : {16'h0000, 1'b1, r[23:9]};
  endfunction
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    apb(0, `ACS_CHSET_BASE, 0);
    cmp(rd, 32'h211);
    apb(0, `ACS_ADCFS_ADDR, 0);
    cmp(rd, 32'h200000);
    apb(0, 12'h020, 0);
    cmp({err, rd[30:0]}, 32'h80000000);
    for (i = 0; i < 4; i++) begin
      ch = $unsigned($random(seed)) % 8;
      uni = 1'($random(seed));
      level <= (i == 0) ? 24'h000000 : 24'($random(seed));
      refMissing <= (i == 3);
      apb(1, `ACS_CHSET_BASE + 12'(ch * 4), {uni, 1'b1, i[0], 8'h03});
      apb(1, `ACS_MODE_ADDR, {ch[2:0], 1'b0, `ACS_MODE_SINGLE});
      waitDone;
      apb(0, `ACS_STAT_ADDR, 0);
      cmp(rd & (32'h1 << ch), 32'h1 << ch);
      apb(0, `ACS_CHST_BASE + 12'(ch * 4), 0);
      cmp(rd & 32'h9, {28'h0, i == 3, 3'b001});
      apb(0, `ACS_DATA_BASE + 12'(ch * 4), 0);
      cmp(rd, expData(level, uni));
      apb(0, `ACS_STAT_ADDR, 0);
      cmp(rd & (32'h1 << ch), 0);
    end
    refMissing <= 0;
    apb(1, `ACS_CFG_ADDR, 1);
    startHoldPin <= 0;
    apb(1, `ACS_MODE_ADDR, {4'h0, `ACS_MODE_SINGLE});
    repeat (80) @(posedge sys_clk);
    cmp({doneN_r, sampling_r}, 2'b10);
    startHoldPin <= 1;
    waitDone;
    apb(1, `ACS_CFG_ADDR, 0);
    for (i = 0; i < 8; i++)
      apb(1, `ACS_CHSET_BASE + 12'(i * 4), i == 0 ? 32'h201 : i == 3 ? 32'h301 : 32'h001);
    apb(1, `ACS_MODE_ADDR, {4'h0, `ACS_MODE_CONT});
    for (i = 0; i < 3; i++) begin
      waitDone;
      repeat (2) @(posedge sys_clk);
      cmp(muxChannel_r, (i % 2 == 0) ? 3 : 0);
    end
    apb(1, `ACS_MODE_ADDR, 0);
    apb(0, `ACS_STAT_ADDR, 0);
    cmp(rd, 0);
    // Doubled channel gain drives the result past full scale
    apb(1, `ACS_CHFS_BASE, 32'h400000);
    apb(1, `ACS_CHSET_BASE, 32'h601);
    level <= 24'hC00000;
    for (i = 0; i < 2; i++) begin
      apb(1, `ACS_MODE_ADDR, i == 0 ? 32'h9 : 32'h1);
      waitDone;
      apb(0, `ACS_DATA_BASE, 0);
      cmp(rd, i == 0 ? 32'hFFFF : 32'h8000);
      apb(0, `ACS_CHST_BASE, 0);
      cmp(rd & 32'h6, 32'h4);
    end
    level <= 24'($random(seed));
    // Self calibration first, then zero before full scale
    for (i = 0; i < 3; i++) begin
      apb(1, `ACS_MODE_ADDR, i == 0 ? 7'h4 : i == 1 ? 7'h6 : 7'h7);
      waitDone;
      apb(0, `ACS_STAT_ADDR, 0);
      cmp(rd[7:0], 8'hFF);
      if (i == 0) begin
        apb(0, `ACS_ADCZS_ADDR, 0);
        cmp(rd, {8'h00, level});
      end
    end
    test_done;
  end
endmodule
`default_nettype wire
